/* File: rtl/mebk_blank_timer.v */
`timescale 1ns/1ps
`default_nettype none
// One blanking interval timer.
module mebk_blank_timer #(
  parameter WIDTH = 8
) (
  input wire clock,
  input wire rst_n,
  input wire enable,
  input wire trigger,
  input wire [WIDTH-1:0] blank_time,
  output reg active,
  output reg [WIDTH-1:0] count
);
  wire ending;

  assign ending = active && (count == blank_time);

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      active <= 1'b0;
      count <= {WIDTH{1'b0}};
    end else if (!enable) begin
      active <= 1'b0;
      count <= {WIDTH{1'b0}};
    end else if (trigger && blank_time != {WIDTH{1'b0}}) begin
      // A new event restarts the interval from zero.
      active <= 1'b1;
      count <= {WIDTH{1'b0}};
    end else if (ending) begin
      active <= 1'b0;
      count <= {WIDTH{1'b0}};
    end else if (active) begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

/* File: rtl/mebk_event_blank.v */
`include "mebk_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module mebk_event_blank #(
  parameter TIME_WIDTH = 8
) (
  input wire clock,
  input wire rst_n,
  input wire [3:0] address,
  input wire [7:0] write_data,
  input wire write_strobe,
  input wire read_strobe,
  output reg [7:0] read_data,
  input wire comparator1_synced_out,
  input wire comparator2_synced_out,
  input wire comparator3_synced_out,
  input wire external_event_pin,
  input wire sync_rise_event,
  input wire sync_fall_event,
  input wire sync_period_event,
  input wire sync_shutdown,
  output wire rise_event,
  output wire fall_event,
  output wire period_event,
  output wire shutdown_level
);
  // Source bit order in every select register: bit0..2 comparators, bit3 pin.
  reg [7:0] blanking_control;
  reg [TIME_WIDTH-1:0] rising_blank_time;
  reg [TIME_WIDTH-1:0] falling_blank_time;
  reg [3:0] rising_blanked_sources;
  reg [3:0] falling_blanked_sources;
  reg [3:0] rise_sel;
  reg [3:0] fall_sel;
  reg [3:0] period_sel;
  reg [3:0] shut_sel;
  reg [3:0] src_prev;
  wire [3:0] src_now;
  wire [3:0] src_rise;
  wire [3:0] blank_mask;
  wire [3:0] live_edge;
  wire [3:0] live_level;
  wire rise_active;
  wire fall_active;
  wire [TIME_WIDTH-1:0] rise_count;
  wire [TIME_WIDTH-1:0] fall_count;
  wire rise_blank_en;
  wire fall_blank_en;

  function mode_is_immediate;
    input [1:0] mode;
    begin
      mode_is_immediate = (mode == `MEBK_MODE_IMM);
    end
  endfunction

  // The pin joins the comparator bits unsynchronised so blanking covers it.
  assign src_now = {external_event_pin, comparator3_synced_out,
                    comparator2_synced_out, comparator1_synced_out};

  // Edge detect on all four sources; only shutdown uses the blanked level.
  assign src_rise = src_now & ~src_prev;

  assign rise_blank_en = mode_is_immediate(blanking_control[`MEBK_REBM_LSB +: 2]);
  assign fall_blank_en = mode_is_immediate(blanking_control[`MEBK_FEBM_LSB +: 2]);

  // With both modes off the mask is zero and sources pass straight through.
  assign blank_mask = (rise_active ? rising_blanked_sources : 4'h0) |
                      (fall_active ? falling_blanked_sources : 4'h0);

  assign live_edge = src_rise & ~blank_mask;
  assign live_level = src_now & ~blank_mask;

  assign rise_event = sync_rise_event | (|(live_edge & rise_sel));
  assign fall_event = sync_fall_event | (|(live_edge & fall_sel));
  assign period_event = sync_period_event | (|(live_edge & period_sel));
  assign shutdown_level = sync_shutdown | (|(live_level & shut_sel));

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      src_prev <= 4'h0;
    end else begin
      src_prev <= src_now;
    end
  end

  // Each edge owns its timer, so the two intervals may overlap freely.
  // Inputs are sampled on the clock, so the start may lag by one period.
  mebk_blank_timer #(
    .WIDTH(TIME_WIDTH)
  ) u_rise_timer (
    .clock(clock),
    .rst_n(rst_n),
    .enable(rise_blank_en),
    .trigger(rise_event),
    .blank_time(rising_blank_time),
    .active(rise_active),
    .count(rise_count)
  );

  mebk_blank_timer #(
    .WIDTH(TIME_WIDTH)
  ) u_fall_timer (
    .clock(clock),
    .rst_n(rst_n),
    .enable(fall_blank_en),
    .trigger(fall_event),
    .blank_time(falling_blank_time),
    .active(fall_active),
    .count(fall_count)
  );

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      blanking_control <= `MEBK_CTRL_RST;
      rising_blank_time <= {TIME_WIDTH{1'b0}};
      falling_blank_time <= {TIME_WIDTH{1'b0}};
      rising_blanked_sources <= `MEBK_SRC_RST;
      falling_blanked_sources <= `MEBK_SRC_RST;
      rise_sel <= `MEBK_SRC_RST;
      fall_sel <= `MEBK_SRC_RST;
      period_sel <= `MEBK_SRC_RST;
      shut_sel <= `MEBK_SRC_RST;
    end else if (write_strobe) begin
      case (address)
        `MEBK_ADDR_CTRL: begin
          blanking_control <= write_data & 8'h33;
        end
        `MEBK_ADDR_RTIME: begin
          rising_blank_time <= write_data[TIME_WIDTH-1:0];
        end
        `MEBK_ADDR_FTIME: begin
          falling_blank_time <= write_data[TIME_WIDTH-1:0];
        end
        `MEBK_ADDR_RSRC: begin
          rising_blanked_sources <= write_data[3:0];
        end
        `MEBK_ADDR_FSRC: begin
          falling_blanked_sources <= write_data[3:0];
        end
        `MEBK_ADDR_RISE_SEL: begin
          rise_sel <= write_data[3:0];
        end
        `MEBK_ADDR_FALL_SEL: begin
          fall_sel <= write_data[3:0];
        end
        `MEBK_ADDR_PER_SEL: begin
          period_sel <= write_data[3:0];
        end
        `MEBK_ADDR_SHUT_SEL: begin
          shut_sel <= write_data[3:0];
        end
        default: begin
        end
      endcase
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      read_data <= 8'h00;
    end else if (read_strobe) begin
      case (address)
        `MEBK_ADDR_CTRL: read_data <= blanking_control;
        `MEBK_ADDR_RTIME: read_data <= rising_blank_time;
        `MEBK_ADDR_FTIME: read_data <= falling_blank_time;
        `MEBK_ADDR_RSRC: read_data <= {4'h0, rising_blanked_sources};
        `MEBK_ADDR_FSRC: read_data <= {4'h0, falling_blanked_sources};
        `MEBK_ADDR_RISE_SEL: read_data <= {4'h0, rise_sel};
        `MEBK_ADDR_FALL_SEL: read_data <= {4'h0, fall_sel};
        `MEBK_ADDR_PER_SEL: read_data <= {4'h0, period_sel};
        `MEBK_ADDR_SHUT_SEL: read_data <= {4'h0, shut_sel};
        `MEBK_ADDR_STATUS: read_data <= {6'h00, fall_active, rise_active};
        default: read_data <= 8'h00;
      endcase
    end else begin
      read_data <= 8'h00;
    end
  end

  // Counters are kept for status visibility in simulation; unused here.
  wire unused_counts;
  assign unused_counts = ^{rise_count, fall_count};
endmodule
`default_nettype wire

/* File: rtl/mebk_regs.vh */
`ifndef MEBK_REGS_VH
`define MEBK_REGS_VH

// Register indices on the plain register port.
`define MEBK_ADDR_CTRL 4'h0
`define MEBK_ADDR_RTIME 4'h1
`define MEBK_ADDR_FTIME 4'h2
`define MEBK_ADDR_RSRC 4'h3
`define MEBK_ADDR_FSRC 4'h4
`define MEBK_ADDR_RISE_SEL 4'h5
`define MEBK_ADDR_FALL_SEL 4'h6
`define MEBK_ADDR_PER_SEL 4'h7
`define MEBK_ADDR_SHUT_SEL 4'h8
`define MEBK_ADDR_STATUS 4'h9

// Blanking control field positions.
`define MEBK_FEBM_LSB 0
`define MEBK_REBM_LSB 4

// Blanking mode codes.
`define MEBK_MODE_OFF 2'h0
`define MEBK_MODE_IMM 2'h1

// Reset values.
`define MEBK_CTRL_RST 8'h00
`define MEBK_TIME_RST 8'h00
`define MEBK_SRC_RST 4'h0

`endif

/* File: sim/mebk_props.sv */
`timescale 1ns/1ps
`default_nettype none
module mebk_props (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic read_strobe,
  input wire logic [7:0] read_data,
  input wire logic comparator1_synced_out,
  input wire logic comparator2_synced_out,
  input wire logic comparator3_synced_out,
  input wire logic external_event_pin,
  input wire logic sync_rise_event,
  input wire logic sync_fall_event,
  input wire logic sync_period_event,
  input wire logic sync_shutdown,
  input wire logic rise_event,
  input wire logic fall_event,
  input wire logic period_event,
  input wire logic shutdown_level
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire [3:0] src = {external_event_pin, comparator3_synced_out, comparator2_synced_out,
    comparator1_synced_out};
  logic [3:0] prev;
  // An edge may only be blamed on a source that was low at the previous clock edge.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) prev <= 4'h0;
    else prev <= src;
  end
  wire [3:0] edg = src & ~prev;
  rise_cause_a: assert property (rise_event |-> sync_rise_event || |edg)
    else $error("rise without cause");
  fall_cause_a: assert property (fall_event |-> sync_fall_event || |edg)
    else $error("fall without cause");
  per_cause_a: assert property (period_event |-> sync_period_event || |edg)
    else $error("period without cause");
  shut_cause_a: assert property (shutdown_level |-> sync_shutdown || |src)
    else $error("shutdown without cause");
  sync_rise_a: assert property (sync_rise_event |-> rise_event)
    else $error("sync rise lost");
  sync_per_a: assert property ($rose(sync_period_event) |-> period_event)
    else $error("sync period lost");
  sync_shut_a: assert property (sync_shutdown [*2] |-> shutdown_level && $past(shutdown_level))
    else $error("sync shutdown lost");
  read_slot_a: assert property (read_data != 8'h00 |-> $past(read_strobe))
    else $error("read data outside its slot");
endmodule
bind mebk_event_blank mebk_props u_props (.*);
`default_nettype wire

/* File: sim/mebk_sources.sv */
`timescale 1ns/1ps
`default_nettype none
module mebk_sources (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] level_req,
  output logic [3:0] lines
);
  // Lines move one clock after a request, so no edge lands in the request's own cycle.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) lines <= 4'h0;
    else lines <= level_req;
  end
endmodule
`default_nettype wire

/* File: sim/tb_modulator_event_input_blanking.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_modulator_event_input_blanking;
  logic clock = 1'b0, rst_n = 1'b0, write_strobe = 1'b0, read_strobe = 1'b0;
  logic sync_rise_event = 1'b0, sync_fall_event = 1'b0;
  logic sync_period_event = 1'b0, sync_shutdown = 1'b0;
  logic [3:0] address = 4'h0, level_req = 4'h0;
  logic [7:0] write_data = 8'h00;
  wire [7:0] read_data;
  wire [3:0] lines;
  wire rise_event, fall_event, period_event, shutdown_level;
  wire [3:0] outs = {shutdown_level, period_event, fall_event, rise_event};
  int num_errors = 0, checks_done = 0;
  initial forever #5 clock = ~clock;
  mebk_sources src_model (.clock(clock), .rst_n(rst_n), .level_req(level_req), .lines(lines));
  mebk_event_blank dut (.*, .comparator1_synced_out(lines[0]), .comparator2_synced_out(lines[1]),
    .comparator3_synced_out(lines[2]), .external_event_pin(lines[3]));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d, checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock) begin address <= a; write_data <= d; write_strobe <= 1'b1; end
    @(posedge clock) write_strobe <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock) begin address <= a; read_strobe <= 1'b1; end
    @(posedge clock) read_strobe <= 1'b0;
    #1 chk(read_data, e);
  endtask
  // Checks the first high cycle of the sources, then the held level one cycle on.
  task automatic probe(input logic [3:0] m, input logic [3:0] e1, input logic [3:0] e2);
    @(posedge clock) level_req <= m;
    @(posedge clock);
    #1 chk({4'h0, outs}, {4'h0, e1});
    @(posedge clock);
    #1 chk({4'h0, outs}, {4'h0, e2});
    @(posedge clock) level_req <= 4'h0;
    repeat (2) @(posedge clock);
  endtask
  task automatic regs_check;
    for (int a = 0; a < 10; a++) rd(a[3:0], 8'h00);
    wr(4'h0, 8'hFF);
    rd(4'h0, 8'h33);
    wr(4'h1, 8'hA5);
    rd(4'h1, 8'hA5);
    wr(4'hF, 8'h5A);
    rd(4'hF, 8'h00);
    wr(4'h0, 8'h00);
  endtask
  task automatic select_check;
    for (int a = 5; a < 9; a++) wr(a[3:0], 8'h01 << (a - 5));
    for (int i = 0; i < 4; i++) probe(4'h1 << i, 4'h1 << i, (i == 3) ? 4'h8 : 4'h0);
    probe(4'h3, 4'h3, 4'h0);
  endtask
  task automatic sync_check;
    @(posedge clock) begin sync_period_event <= 1'b1; sync_shutdown <= 1'b1; end
    @(posedge clock);
    #1 chk({4'h0, outs}, 8'h0C);
    @(posedge clock) begin sync_period_event <= 1'b0; sync_shutdown <= 1'b0; end
  endtask
  // Each entry: control, fall-trigger flag and blank time, expected first-cycle events.
  task automatic blank_check;
    logic [15:0] tc [8] = '{16'h1020, 16'h101C, 16'h002C, 16'h302C, 16'h202C, 16'h012C,
      16'h01A0, 16'h019C};
    for (int a = 3; a < 9; a++) wr(a[3:0], (a == 5 || a == 6) ? 8'h00 : 8'h02);
    for (int i = 0; i < 8; i++) begin
      wr(4'h0, tc[i][15:8]);
      wr(4'h1, {6'h00, tc[i][5:4]});
      wr(4'h2, {6'h00, tc[i][5:4]});
      @(posedge clock) if (tc[i][7]) sync_fall_event <= 1'b1; else sync_rise_event <= 1'b1;
      @(posedge clock) begin sync_rise_event <= 1'b0; sync_fall_event <= 1'b0; end
      probe(4'h2, tc[i][3:0], 4'h8);
    end
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    regs_check();
    select_check();
    sync_check();
    blank_check();
    end_sim();
  end
  initial begin
    #100000;
    num_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
